// ### rtl/wwd_top.sv
// Function
// - When enabled, counter expiry without reload asserts the system reset, or the interrupt when reset is off.
// - Enable is set-only by software; cleared by reset or watchdog event.
// - A wrong or broken feed sequence is a fault: reset or interrupt.
// - A flag records that the last chip reset came from the watchdog.
// - Programmable 24-bit counter clocked via prescaler from chosen clock.
// - Period is count times four clock periods; count 256 to 2^24.
// - Plain variant selects internal RC, watchdog oscillator or main clock.
// - Windowed variant selects only internal RC or watchdog oscillator.
// - With windowing on, feeds while the count is above the window value are faults.
// - Optional warning interrupt when the counter reaches a set point.
// - The watchdog reset is one of the chip reset sources.
//
// Implementation choices: the address map and register access over APB.
`timescale 1ns/10ps
`include "wwd_cfg.svh"

module wwd_top #(
  parameter int WINDOWED = 1
) (
  input  wire logic        sys_clk,     // 20 MHz bus clock
  input  wire logic        rst,         // Power-on, pin or brown-out reset
  input  wire logic        psel,        // APB select
  input  wire logic        penable,     // APB access phase
  input  wire logic        pwrite,      // APB direction
  input  wire logic [11:0] paddr,       // APB byte address
  input  wire logic [31:0] pwdata,      // APB write data
  output logic      [31:0] prdata,      // APB read data
  output logic             pready,      // APB ready
  output logic             pslverr,     // APB error on unmapped address
  input  wire logic        irc_clk_in,  // Internal RC oscillator
  input  wire logic        wdo_clk_in,  // Dedicated watchdog oscillator
  input  wire logic        main_clk_in, // Main clock
  output logic             chip_rst,    // Watchdog chip reset request
  output logic             wdt_irq      // Watchdog interrupt level
);
  import wwd_pkg::*;

  generate
    if (WINDOWED != 0 && WINDOWED != 1) begin : g_bad_param
      $error("WINDOWED must be 0 or 1");
    end
  endgenerate

  localparam logic [1:0] PRE_LAST = 2'(`WWD_PRESCALE - 1);
  localparam logic [2:0] PULSE_LAST = 3'(`WWD_RST_PULSE - 1);

  function automatic logic is_ofs(input logic [11:0] a,
                                  input logic [11:0] ofs);
    is_ofs = (a == ofs);
  endfunction

  logic [31:0]  prdata_ff;
  logic         pready_ff;
  logic         pslverr_ff;
  logic         en_ff;
  logic         rsten_ff;
  logic         winen_ff;
  logic         tof_ff;
  logic         warnf_ff;
  logic         rstflg_ff;
  logic [23:0]  reload_ff;
  logic [23:0]  warn_ff;
  logic [23:0]  window_ff;
  wwd_src_type  src_ff;
  wwd_feed_type feed_ff;
  logic [2:0]   irc_sync_ff;
  logic [2:0]   wdo_sync_ff;
  logic [2:0]   main_sync_ff;
  logic [1:0]   pre_ff;
  logic [23:0]  count_ff;
  logic         en_s1_ff;
  logic         en_s2_ff;
  logic         feed_s1_ff;
  logic         feed_s2_ff;
  logic [23:0]  load_s1_ff;
  logic [23:0]  load_s2_ff;
  logic         chip_rst_ff;
  logic [2:0]   pulse_ff;
  logic         wdt_irq_ff;

  logic         acc;
  logic         wr;
  logic         mapped;
  logic         feed_wr;
  logic         feed_ok;
  logic         feed_bad;
  logic         early;
  logic         tick;
  logic         src_edge;
  logic         timeout;
  logic         warn_hit;
  logic         fault;
  logic         event_any;
  logic         fire_rst;
  logic         fire_irq;
  logic         tof_clr;
  logic         warnf_clr;

  assign prdata  = prdata_ff;
  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;
  assign chip_rst = chip_rst_ff;
  assign wdt_irq  = wdt_irq_ff;

  // An access completes on the edge where the slave shows ready.
  assign acc    = psel && penable && pready_ff;
  assign wr     = acc && pwrite;
  assign mapped = is_ofs(paddr, `WWD_OFS_MODE)   ||
                  is_ofs(paddr, `WWD_OFS_RELOAD) ||
                  is_ofs(paddr, `WWD_OFS_FEED)   ||
                  is_ofs(paddr, `WWD_OFS_COUNT)  ||
                  is_ofs(paddr, `WWD_OFS_CLKSEL) ||
                  is_ofs(paddr, `WWD_OFS_WARN)   ||
                  is_ofs(paddr, `WWD_OFS_WINDOW);

  // Feed sequencing: second value must be the next mapped access after the first.
  assign feed_wr = wr && is_ofs(paddr, `WWD_OFS_FEED);
  assign feed_ok = feed_wr && (feed_ff == WWD_FEED_ARMED) &&
                   (pwdata[7:0] == `WWD_FEED_SECOND);
  assign feed_bad = acc && mapped && (feed_ff == WWD_FEED_ARMED) &&
                    !feed_ok;
  // Count runs down, so a count above the window value is too early.
  assign early = winen_ff && (count_ff > window_ff);
  assign fault = en_ff && (feed_bad || (feed_ok && early));

  assign src_edge = (src_ff == WWD_SRC_IRC)  ? (irc_sync_ff[1] &&
                                                !irc_sync_ff[2]) :
                    (src_ff == WWD_SRC_WDO)  ? (wdo_sync_ff[1] &&
                                                !wdo_sync_ff[2]) :
                    (main_sync_ff[1] && !main_sync_ff[2]);
  assign tick     = src_edge && (pre_ff == PRE_LAST);
  assign timeout  = en_s2_ff && tick && (count_ff == 24'h000000);
  assign warn_hit = en_s2_ff && tick && (count_ff == warn_ff) &&
                    (warn_ff != 24'h000000);
  assign event_any = timeout || fault;
  assign fire_rst  = event_any && rsten_ff;
  assign fire_irq  = event_any && !rsten_ff;

  assign tof_clr   = wr && is_ofs(paddr, `WWD_OFS_MODE) &&
                     pwdata[`WWD_MODE_TOF];
  assign warnf_clr = wr && is_ofs(paddr, `WWD_OFS_MODE) &&
                     pwdata[`WWD_MODE_WARNF];

  // APB slave: data and ready prepared in the setup cycle, so every
  // access is answered in its first access-phase cycle.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h00000000;
    end else if (psel && !penable) begin
      pready_ff  <= 1'b1;
      pslverr_ff <= !mapped;
      prdata_ff  <= 32'h00000000;
      if (!pwrite) begin
        if (is_ofs(paddr, `WWD_OFS_MODE)) begin
          prdata_ff <= {26'h0000000, rstflg_ff, winen_ff, warnf_ff,
                        tof_ff, rsten_ff, en_ff};
        end else if (is_ofs(paddr, `WWD_OFS_RELOAD)) begin
          prdata_ff <= {8'h00, reload_ff};
        end else if (is_ofs(paddr, `WWD_OFS_COUNT)) begin
          prdata_ff <= {8'h00, count_ff};
        end else if (is_ofs(paddr, `WWD_OFS_CLKSEL)) begin
          prdata_ff <= {30'h00000000, src_ff};
        end else if (is_ofs(paddr, `WWD_OFS_WARN)) begin
          prdata_ff <= {8'h00, warn_ff};
        end else if (is_ofs(paddr, `WWD_OFS_WINDOW)) begin
          prdata_ff <= {8'h00, window_ff};
        end
      end
    end else begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end
  end

  // Enable may only be set by software; a watchdog event drops it.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      en_ff <= 1'b0;
    end else if (event_any) begin
      en_ff <= 1'b0;
    end else if (wr && is_ofs(paddr, `WWD_OFS_MODE) &&
                 pwdata[`WWD_MODE_EN]) begin
      en_ff <= 1'b1;
    end
  end

  // Plain configuration registers.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rsten_ff  <= 1'b0;
      winen_ff  <= 1'b0;
      reload_ff <= `WWD_RST_RELOAD;
      warn_ff   <= `WWD_RST_WARN;
      window_ff <= `WWD_RST_WINDOW;
    end else if (wr) begin
      if (is_ofs(paddr, `WWD_OFS_MODE)) begin
        rsten_ff <= pwdata[`WWD_MODE_RSTEN];
        winen_ff <= pwdata[`WWD_MODE_WINEN] && (WINDOWED == 1);
      end
      if (is_ofs(paddr, `WWD_OFS_RELOAD)) begin
        // Counts below the floor are raised to it.
        reload_ff <= (pwdata[23:0] < `WWD_MIN_RELOAD) ?
                     `WWD_MIN_RELOAD : pwdata[23:0];
      end
      if (is_ofs(paddr, `WWD_OFS_WARN)) begin
        warn_ff <= pwdata[23:0];
      end
      if (is_ofs(paddr, `WWD_OFS_WINDOW)) begin
        window_ff <= pwdata[23:0];
      end
    end
  end

  // Clock source select; the windowed variant has no main clock choice.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      src_ff <= wwd_src_type'(`WWD_RST_CLKSEL);
    end else if (wr && is_ofs(paddr, `WWD_OFS_CLKSEL)) begin
      if (pwdata[1:0] == 2'h0) begin
        src_ff <= WWD_SRC_IRC;
      end else if (pwdata[1:0] == 2'h1) begin
        src_ff <= WWD_SRC_WDO;
      end else if (pwdata[1:0] == 2'h2 && WINDOWED == 0) begin
        src_ff <= WWD_SRC_MAIN;
      end else begin
        src_ff <= src_ff;
      end
    end
  end

  // Feed sequence state.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      feed_ff <= WWD_FEED_IDLE;
    end else begin
      case (feed_ff)
        WWD_FEED_IDLE: begin
          if (feed_wr && pwdata[7:0] == `WWD_FEED_FIRST) begin
            feed_ff <= WWD_FEED_ARMED;
          end
        end
        WWD_FEED_ARMED: begin
          if (acc && mapped) begin
            feed_ff <= WWD_FEED_IDLE;
          end
        end
        default: begin
          feed_ff <= WWD_FEED_IDLE;
        end
      endcase
    end
  end

  // Event flags; a new event wins over a clear in the same cycle.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tof_ff   <= 1'b0;
      warnf_ff <= 1'b0;
    end else begin
      tof_ff   <= fire_irq || (tof_ff && !tof_clr);
      warnf_ff <= warn_hit || (warnf_ff && !warnf_clr);
    end
  end

  // Of the resets, only the outside ones clear this flag, so it survives the
  // watchdog's own chip reset. Software clears it by writing one.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rstflg_ff <= 1'b0;
    end else if (fire_rst) begin
      rstflg_ff <= 1'b1;
    end else if (wr && is_ofs(paddr, `WWD_OFS_MODE) &&
                 pwdata[`WWD_MODE_RSTFLG]) begin
      rstflg_ff <= 1'b0;
    end
  end

  // Oscillator pins: two flops before use, third for edge detection.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irc_sync_ff  <= 3'h0;
      wdo_sync_ff  <= 3'h0;
      main_sync_ff <= 3'h0;
    end else begin
      irc_sync_ff  <= {irc_sync_ff[1:0], irc_clk_in};
      wdo_sync_ff  <= {wdo_sync_ff[1:0], wdo_clk_in};
      main_sync_ff <= {main_sync_ff[1:0], main_clk_in};
    end
  end

  // Fixed divide-by-four prescaler on watchdog clock edges.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pre_ff <= 2'h0;
    end else if (!en_s2_ff) begin
      pre_ff <= 2'h0;
    end else if (src_edge) begin
      pre_ff <= pre_ff + 2'h1;
    end
  end

  // Enable and reload pass two stages before steering the counter.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      en_s1_ff   <= 1'b0;
      en_s2_ff   <= 1'b0;
      feed_s1_ff <= 1'b0;
      feed_s2_ff <= 1'b0;
      load_s1_ff <= `WWD_RST_RELOAD;
      load_s2_ff <= `WWD_RST_RELOAD;
    end else begin
      en_s1_ff   <= en_ff;
      en_s2_ff   <= en_s1_ff && en_ff;
      feed_s1_ff <= (feed_ok && !fault) || (en_ff && !en_s1_ff);
      feed_s2_ff <= feed_s1_ff;
      load_s1_ff <= reload_ff;
      load_s2_ff <= load_s1_ff;
    end
  end

  // The 24-bit down-counter; a completed feed reloads it.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      count_ff <= `WWD_RST_RELOAD;
    end else if (feed_s2_ff) begin
      count_ff <= load_s2_ff;
    end else if (event_any) begin
      count_ff <= load_s2_ff;
    end else if (tick && en_s2_ff && count_ff != 24'h000000) begin
      count_ff <= count_ff - 24'h000001;
    end
  end

  // Chip reset request, held for a few cycles to reach every block.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      chip_rst_ff <= 1'b0;
      pulse_ff    <= 3'h0;
    end else if (fire_rst) begin
      chip_rst_ff <= 1'b1;
      pulse_ff    <= 3'h0;
    end else if (chip_rst_ff) begin
      pulse_ff <= pulse_ff + 3'h1;
      if (pulse_ff == PULSE_LAST) begin
        chip_rst_ff <= 1'b0;
      end
    end
  end

  // Interrupt level follows the sticky flags.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wdt_irq_ff <= 1'b0;
    end else begin
      wdt_irq_ff <= tof_ff || warnf_ff;
    end
  end

endmodule

// ### rtl/wwd_cfg.svh
`ifndef WWD_CFG_SVH
`define WWD_CFG_SVH

// Register byte offsets.
`define WWD_OFS_MODE     12'h000
`define WWD_OFS_RELOAD   12'h004
`define WWD_OFS_FEED     12'h008
`define WWD_OFS_COUNT    12'h00c
`define WWD_OFS_CLKSEL   12'h010
`define WWD_OFS_WARN     12'h014
`define WWD_OFS_WINDOW   12'h018

// Mode register bit positions.
`define WWD_MODE_EN      0
`define WWD_MODE_RSTEN   1
`define WWD_MODE_TOF     2
`define WWD_MODE_WARNF   3
`define WWD_MODE_WINEN   4
`define WWD_MODE_RSTFLG  5

// Reset values.
`define WWD_RST_RELOAD   24'hffffff
`define WWD_RST_WARN     24'h000000
`define WWD_RST_WINDOW   24'hffffff
`define WWD_RST_CLKSEL   2'h0

// Smallest programmable count (256 ticks, zero included).
`define WWD_MIN_RELOAD   24'h0000ff

// Feed pair.
`define WWD_FEED_FIRST   8'haa
`define WWD_FEED_SECOND  8'h55

// Timing counts.
`define WWD_PRESCALE     4
`define WWD_RST_PULSE    4

`endif

// ### rtl/wwd_pkg.sv
package wwd_pkg;

  typedef enum logic [1:0] {
    WWD_SRC_IRC,
    WWD_SRC_WDO,
    WWD_SRC_MAIN
  } wwd_src_type;

  typedef enum logic [1:0] {
    WWD_FEED_IDLE,
    WWD_FEED_ARMED
  } wwd_feed_type;

endpackage

// ### test/wwd_checker.sv
`timescale 1ns/10ps
`include "wwd_cfg.svh"

module wwd_checker #(
  parameter int WINDOWED = 1
) (
  input wire logic        sys_clk,     // Bus clock
  input wire logic        rst,         // Async reset
  input wire logic        psel,        // APB select
  input wire logic        penable,     // APB access
  input wire logic        pwrite,      // APB direction
  input wire logic [11:0] paddr,       // APB address
  input wire logic [31:0] pwdata,      // APB write data
  input wire logic [31:0] prdata,      // APB read data
  input wire logic        pready,      // APB ready
  input wire logic        pslverr,     // APB error
  input wire logic        irc_clk_in,  // RC oscillator
  input wire logic        wdo_clk_in,  // Watchdog oscillator
  input wire logic        main_clk_in, // Main clock
  input wire logic        chip_rst,    // Reset request
  input wire logic        wdt_irq      // Interrupt
);
  wire logic rd_acc = pready && !pwrite;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  AST_READY_FIRST: assert property ((psel && !penable) ##1 (psel && penable)
    |-> pready) else $error("pready missing in first access cycle");
  AST_READY_ONLY_ACCESS: assert property (pready |-> psel && penable)
    else $error("pready outside access phase");
  AST_READY_ONE: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  AST_ERR_MAP: assert property (pready && paddr[1:0] == 2'h0
    |-> pslverr == (paddr > `WWD_OFS_WINDOW)) else $error("pslverr wrong");
  AST_ERR_READ_ZERO: assert property (rd_acc && pslverr |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  AST_MODE_WIDTH: assert property (
    rd_acc && paddr == `WWD_OFS_MODE |-> prdata[31:6] == 26'h0)
    else $error("mode reserved bits set");
  AST_REG_WIDTH: assert property (
    rd_acc && paddr inside {`WWD_OFS_RELOAD, `WWD_OFS_COUNT, `WWD_OFS_WARN,
    `WWD_OFS_WINDOW} |-> prdata[31:24] == 8'h0) else $error("wide count");
  AST_RELOAD_MIN: assert property (
    rd_acc && paddr == `WWD_OFS_RELOAD |-> prdata[23:0] >= `WWD_MIN_RELOAD)
    else $error("reload below minimum");
  AST_CLKSEL_SRC: assert property (
    rd_acc && paddr == `WWD_OFS_CLKSEL
    |-> prdata <= (WINDOWED != 0 ? 32'h1 : 32'h2)) else $error("bad source");
  AST_RST_PULSE: assert property (
    $rose(chip_rst) |-> chip_rst [*4] ##1 !chip_rst)
    else $error("reset pulse not four cycles");

  COV_TIMEOUT: cover property ($rose(chip_rst));
  COV_IRQ: cover property ($rose(wdt_irq));
  COV_UNMAPPED: cover property (pready && pslverr);
endmodule

bind wwd_top wwd_checker #(.WINDOWED(WINDOWED)) u_wwd_checker (
  .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .irc_clk_in(irc_clk_in),
  .wdo_clk_in(wdo_clk_in), .main_clk_in(main_clk_in),
  .chip_rst(chip_rst), .wdt_irq(wdt_irq));

// ### test/wwd_top_test.sv
`timescale 1ns/10ps
`include "wwd_cfg.svh"

module wwd_top_test;
  typedef struct packed {
    logic        w;
    logic [11:0] a;
    logic [31:0] d;
    logic        e;
  } wwd_row_type;

  // Expected time-out in bus cycles: one RC clock period is 8 bus cycles, four periods per tick.
  localparam int TOUT = (`WWD_MIN_RELOAD + 1) * `WWD_PRESCALE * 8;

  logic        sys_clk;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic        irc_clk_in;
  logic        wdo_clk_in;
  logic        main_clk_in;
  logic [3:0]  osc_cnt;
  logic [31:0] rdat;
  logic        rerr;
  wire  [31:0] prdata;
  wire         pready;
  wire         pslverr;
  wire         chip_rst;
  wire         wdt_irq;
  int          cyc;
  int          n;
  int          bad_count;
  int          check_count;

  wwd_row_type rows [16] = '{
    '{1'b0, `WWD_OFS_RELOAD, 32'h00ffffff, 1'b0},
    '{1'b0, `WWD_OFS_WARN,   32'h00000000, 1'b0},
    '{1'b0, `WWD_OFS_WINDOW, 32'h00ffffff, 1'b0},
    '{1'b0, `WWD_OFS_CLKSEL, 32'h00000000, 1'b0},
    '{1'b0, `WWD_OFS_MODE,   32'h00000000, 1'b0},
    '{1'b1, `WWD_OFS_RELOAD, 32'h00001234, 1'b0},
    '{1'b0, `WWD_OFS_RELOAD, 32'h00001234, 1'b0},
    '{1'b1, `WWD_OFS_RELOAD, 32'h00000010, 1'b0},
    '{1'b0, `WWD_OFS_RELOAD, 32'h000000ff, 1'b0},
    '{1'b1, `WWD_OFS_CLKSEL, 32'h00000002, 1'b0},
    '{1'b0, `WWD_OFS_CLKSEL, 32'h00000000, 1'b0},
    '{1'b1, `WWD_OFS_CLKSEL, 32'h00000001, 1'b0},
    '{1'b0, `WWD_OFS_CLKSEL, 32'h00000001, 1'b0},
    '{1'b1, `WWD_OFS_CLKSEL, 32'h00000000, 1'b0},
    '{1'b0, 12'h01c,         32'h00000000, 1'b1},
    '{1'b1, 12'h020,         32'h00000000, 1'b1}
  };

  wwd_top #(.WINDOWED(1)) dut (
    .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irc_clk_in(irc_clk_in),
    .wdo_clk_in(wdo_clk_in), .main_clk_in(main_clk_in),
    .chip_rst(chip_rst), .wdt_irq(wdt_irq));

  always #25 sys_clk = ~sys_clk;

  // Oscillators run at an eighth of the bus rate or slower, as the syncs need.
  always @(posedge sys_clk) begin
    osc_cnt <= osc_cnt + 4'h1;
    irc_clk_in <= osc_cnt[2];
    wdo_clk_in <= osc_cnt[3];
    main_clk_in <= ~osc_cnt[2];
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      bad_count++;
      $display("Error at %0t: bench timeout reached", $time);
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("Checks: %0d, errors: %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic        w,
                     input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // No fixed wait is assumed; only the bench timeout ends a hang.
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic feed(input logic [31:0] second);
    apb(1'b1, `WWD_OFS_FEED, {24'h0, `WWD_FEED_FIRST});
    apb(1'b1, `WWD_OFS_FEED, second);
  endtask

  initial begin
    sys_clk = 1'b0;
    rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {irc_clk_in, wdo_clk_in, main_clk_in, osc_cnt} = '0;
    {cyc, bad_count, check_count} = '0;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    chk({29'h0, chip_rst, wdt_irq, pready}, 32'h0);
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].w ? rows[i].d : 32'h0);
      if (!rows[i].w) chk(rdat, rows[i].d);
      chk({31'h0, rerr}, {31'h0, rows[i].e});
    end
    apb(1'b1, `WWD_OFS_MODE, 32'h1);
    apb(1'b1, `WWD_OFS_MODE, 32'h0);
    apb(1'b0, `WWD_OFS_MODE, 32'h0);
    chk(rdat, 32'h1);
    repeat (300) @(posedge sys_clk);
    apb(1'b0, `WWD_OFS_COUNT, 32'h0);
    chk(32'(rdat[23:0] < 24'hfe), 32'h1);
    feed({24'h0, `WWD_FEED_SECOND});
    repeat (2) @(posedge sys_clk);
    apb(1'b0, `WWD_OFS_COUNT, 32'h0);
    chk(32'(rdat[23:0] >= 24'hfe), 32'h1);
    // A broken feed in interrupt mode must flag and disarm the watchdog.
    feed(32'h0);
    repeat (3) @(posedge sys_clk);
    chk(32'(wdt_irq), 32'h1);
    apb(1'b0, `WWD_OFS_MODE, 32'h0);
    chk(rdat, 32'h4);
    apb(1'b1, `WWD_OFS_MODE, 32'h4);
    repeat (2) @(posedge sys_clk);
    chk(32'(wdt_irq), 32'h0);
    apb(1'b1, `WWD_OFS_WINDOW, 32'h10);
    apb(1'b1, `WWD_OFS_MODE, 32'h11);
    feed({24'h0, `WWD_FEED_SECOND});
    repeat (3) @(posedge sys_clk);
    apb(1'b0, `WWD_OFS_MODE, 32'h0);
    chk(rdat, 32'h14);
    apb(1'b1, `WWD_OFS_MODE, 32'h4);
    apb(1'b1, `WWD_OFS_WINDOW, 32'hff);
    apb(1'b1, `WWD_OFS_MODE, 32'h11);
    repeat (40) @(posedge sys_clk);
    feed({24'h0, `WWD_FEED_SECOND});
    apb(1'b0, `WWD_OFS_MODE, 32'h0);
    chk(rdat, 32'h11);
    apb(1'b1, `WWD_OFS_WARN, 32'h80);
    n = 0;
    while (wdt_irq !== 1'b1) begin
      @(posedge sys_clk);
      n++;
    end
    apb(1'b0, `WWD_OFS_MODE, 32'h0);
    chk(rdat, 32'h19);
    rst <= 1'b1;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    apb(1'b0, `WWD_OFS_MODE, 32'h0);
    chk(rdat, 32'h0);
    apb(1'b1, `WWD_OFS_RELOAD, 32'hff);
    apb(1'b1, `WWD_OFS_MODE, 32'h3);
    n = 0;
    while (chip_rst !== 1'b1) begin
      @(posedge sys_clk);
      n++;
    end
    chk(32'(n >= TOUT - 48 && n <= TOUT + 48), 32'h1);
    repeat (8) @(posedge sys_clk);
    apb(1'b0, `WWD_OFS_MODE, 32'h0);
    chk(rdat, 32'h22);
    apb(1'b1, `WWD_OFS_MODE, 32'h22);
    apb(1'b0, `WWD_OFS_MODE, 32'h0);
    chk(rdat, 32'h2);
    end_of_test();
  end
endmodule
